// File: bench/fbp_req_model.sv
// Requester model: fetch path, data path and debugger on one port.
// Assumes the gate takes a request on a rising edge with ready high.
`timescale 1ns/1ps
`default_nettype none
module fbp_req_model
  import fbp_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     req_ready_i,
  input  wire logic     rsp_valid_i,
  input  wire fbp_rsp_t rsp_i,
  output var logic      req_valid_o,
  output var fbp_req_t  req_o
);
  // Answers that never came; the bench adds them to its failures
  int n_late = 0;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // n counts cycles from the take to the answer
  task automatic xfer(input fbp_op_t op, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output fbp_rsp_t r, output int n);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_o = '{op, a, d};
    while (req_ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    @(negedge clk_i);
    req_valid_o = 1'b0;
    // Released lines toggle so a stale value is never trusted
    req_o = ~req_o;
    n = 0;
    while (rsp_valid_i !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (rsp_valid_i !== 1'b1) n_late++;
    r = rsp_i;
  endtask : xfer
endmodule : fbp_req_model
`default_nettype wire

// File: bench/flash_block_erase_protect_tb_top.sv
// Testbench for the flash erase/protect gate.
// Assumes the requester model and the gate's inline assertions.
`timescale 1ns/1ps
`default_nettype none
module flash_block_erase_protect_tb_top
  import fbp_pkg::*;
;
  logic               mclk, rst, rdy, rv, vclr, viol, req_valid;
  logic [REGIONS-1:0] ro_set, xo_set, ro, xo;
  fbp_req_t           req;
  fbp_rsp_t           rsp, r;
  int                 n, n_fail, checks_done;
  fbp_gate dut_u (.mclk_i(mclk), .reset_i(rst), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(rdy), .rsp_o(rsp), .rsp_valid_o(rv), .ro_set_i(ro_set), .xo_set_i(xo_set),
    .ro_o(ro), .xo_o(xo), .viol_clr_i(vclr), .viol_o(viol));
  fbp_req_model model_u (.clk_i(mclk), .req_ready_i(rdy), .rsp_valid_i(rv), .rsp_i(rsp),
    .req_valid_o(req_valid), .req_o(req));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrap_up();
    n_fail += model_u.n_late;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic t_erase();
    model_u.xfer(FBP_ERASE, 16'h0000, 32'h0, r, n);
    chk("erase lat", 32'(n), 32'h100);
    model_u.xfer(FBP_PROGRAM, 16'h0010, 32'h1234_5678, r, n);
    model_u.xfer(FBP_ERASE, 16'h0400, 32'h0, r, n);
    model_u.xfer(FBP_DREAD, 16'h0410, 32'h0, r, n);
    chk("erased", r.rdata, ERASED_WORD);
    model_u.xfer(FBP_DREAD, 16'h0010, 32'h0, r, n);
    chk("neighbour", r.rdata, 32'h1234_5678);
    model_u.xfer(FBP_ERASE, 16'hFC00, 32'h0, r, n);
    model_u.xfer(FBP_DREAD, 16'hFFFC, 32'h0, r, n);
    chk("top word", r.rdata, ERASED_WORD);
    model_u.xfer(FBP_ERASE, 16'h0800, 32'h0, r, n);
    model_u.xfer(FBP_PROGRAM, 16'h0800, 32'hA5A5_A5A5, r, n);
  endtask : t_erase
  task automatic t_ro();
    @(negedge mclk);
    ro_set = 32'h1;
    @(negedge mclk);
    ro_set = '0;
    model_u.xfer(FBP_ERASE, 16'h0400, 32'h0, r, n);
    chk("ro erase", {r.denied, 31'(n)}, 32'h8000_0000);
    model_u.xfer(FBP_PROGRAM, 16'h0010, 32'h0, r, n);
    chk("ro prog", 32'(r.denied), 32'h1);
    model_u.xfer(FBP_DREAD, 16'h0010, 32'h0, r, n);
    chk("ro read", r.rdata, 32'h1234_5678);
    chk("viol", {ro[0], 31'(viol)}, 32'h8000_0001);
    vclr = 1'b1;
    @(negedge mclk);
    vclr = 1'b0;
    @(negedge mclk);
    chk("viol clr", 32'(viol), 32'h0);
  endtask : t_ro
  task automatic t_xo();
    fbp_op_t bad[4] = '{FBP_DREAD, FBP_DBG_READ, FBP_PROGRAM, FBP_ERASE};
    @(negedge mclk);
    xo_set = 32'h2;
    @(negedge mclk);
    xo_set = '0;
    chk("xo state", xo, 32'h0000_0002);
    foreach (bad[i]) begin
      model_u.xfer(bad[i], 16'h0804, 32'h0, r, n);
      chk("xo deny", {r.denied, r.ok, 30'(r.rdata)}, 32'h8000_0000);
      chk("xo data", r.rdata, 32'h0);
    end
    model_u.xfer(FBP_IFETCH, 16'h0800, 32'h0, r, n);
    chk("xo fetch", r.rdata, 32'hA5A5_A5A5);
    model_u.xfer(FBP_DREAD, 16'h0010, 32'h0, r, n);
    chk("region", {r.ok, 31'(viol)}, 32'h8000_0001);
  endtask : t_xo
  task automatic t_rst();
    @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    chk("rst ro", ro, 32'h0);
    chk("rst xo", xo, 32'h0);
    chk("rst viol", 32'(viol), 32'h0);
    model_u.xfer(FBP_DREAD, 16'h0804, 32'h0, r, n);
    chk("rst read", r.rdata, ERASED_WORD);
  endtask : t_rst
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {rst, vclr, ro_set, xo_set} = {1'b1, 1'b0, 64'h0};
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    chk("reset", {rdy, viol, ro[29:0]}, 32'h8000_0000);
    chk("reset xo", xo, 32'h0);
    t_erase();
    t_ro();
    t_xo();
    t_rst();
    wrap_up();
  end
endmodule : flash_block_erase_protect_tb_top
`default_nettype wire

// File: rtl/fbp_gate.sv
// Flash array with per-unit erase and per-region access protection.
// Assumes requesters hold req until ack; all inputs synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module fbp_gate
  import fbp_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire logic               req_valid_i,
  input  wire fbp_req_t           req_i,
  output logic                    req_ready_o,
  output fbp_rsp_t                rsp_o,
  output logic                    rsp_valid_o,
  input  wire logic [REGIONS-1:0] ro_set_i,
  input  wire logic [REGIONS-1:0] xo_set_i,
  output logic [REGIONS-1:0]      ro_o,
  output logic [REGIONS-1:0]      xo_o,
  input  wire logic               viol_clr_i,
  output logic                    viol_o
);
  typedef enum logic [1:0] {FBP_IDLE, FBP_WIPE} fbp_state_t;

  logic [31:0]        mem_q [WORDS];
  fbp_state_t         state_q;
  logic [UOFF_W-1:0]  wipe_cnt_q;
  logic [UNIT_W-1:0]  wipe_unit_q;
  logic [REGIONS-1:0] ro_q;
  logic [REGIONS-1:0] xo_q;
  logic               viol_q;
  logic [REG_W-1:0]   region;
  logic               locked;
  logic               deny;
  logic               take;
  logic [WADDR_W-1:0] waddr;

  assign region = req_i.addr[ADDR_W-1:REG_LSB];
  assign waddr  = req_i.addr[ADDR_W-1:WORD_LSB];
  assign locked = ro_q[region] | xo_q[region];
  always_comb begin
    unique case (req_i.op)
      FBP_PROGRAM, FBP_ERASE: deny = locked;
      FBP_DREAD, FBP_DBG_READ: deny = xo_q[region];
      default: deny = 1'b0;
    endcase
  end
  assign req_ready_o = (state_q == FBP_IDLE);
  assign take        = req_valid_i & req_ready_o;
  assign ro_o        = ro_q;
  assign xo_o        = xo_q;
  assign viol_o      = viol_q;

  // Protection bits only ever set; clearing needs a reset
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ro_q <= PROT_RST;
      xo_q <= PROT_RST;
    end else begin
      ro_q <= ro_q | ro_set_i;
      xo_q <= xo_q | xo_set_i;
    end
  end

  // Set wins over clear
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      viol_q <= 1'b0;
    end else if (take && deny) begin
      viol_q <= 1'b1;
    end else if (viol_clr_i) begin
      viol_q <= 1'b0;
    end
  end

  // Erase wipes one word per cycle so no wide write port is needed
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q     <= FBP_IDLE;
      wipe_cnt_q  <= '0;
      wipe_unit_q <= '0;
    end else begin
      unique case (state_q)
        FBP_IDLE: begin
          if (take && !deny && req_i.op == FBP_ERASE) begin
            state_q     <= FBP_WIPE;
            wipe_unit_q <= req_i.addr[ADDR_W-1:UNIT_LSB];
            wipe_cnt_q  <= '0;
          end
        end
        FBP_WIPE: begin
          wipe_cnt_q <= wipe_cnt_q + 1'b1;
          if (&wipe_cnt_q) begin
            state_q <= FBP_IDLE;
          end
        end
      endcase
    end
  end

  // Array contents are not reset, as real flash keeps them
  always_ff @(posedge mclk_i) begin
    if (state_q == FBP_WIPE) begin
      mem_q[{wipe_unit_q, wipe_cnt_q}] <= ERASED_WORD;
    end else if (take && !deny && req_i.op == FBP_PROGRAM) begin
      // Flash programming only clears bits
      mem_q[waddr] <= mem_q[waddr] & req_i.wdata;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
    end else begin
      rsp_valid_o <= (take && !(req_i.op == FBP_ERASE && !deny))
                     || (state_q == FBP_WIPE && &wipe_cnt_q);
      if (take) begin
        rsp_o.ok     <= !deny;
        rsp_o.denied <= deny;
        rsp_o.rdata  <= (deny || req_i.op > FBP_DBG_READ) ? '0 : mem_q[waddr];
      end
    end
  end

  ro_lock_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_PROGRAM && ro_q[region] |=> rsp_valid_o && rsp_o.denied)
    else $error("program of read-only region not refused");
  xo_lock_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_ERASE && xo_q[region] |=> state_q == FBP_IDLE && rsp_o.denied)
    else $error("erase of execute-only region not refused");
  xo_read_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_DBG_READ && xo_q[region] |=> rsp_o.rdata == 32'h0000_0000)
    else $error("debug read leaked execute-only data");
  xo_fetch_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_IFETCH |=> rsp_o.ok)
    else $error("instruction fetch refused");
  viol_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && deny |=> viol_q)
    else $error("violation flag not set");
  viol_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    viol_q && !viol_clr_i |=> viol_q)
    else $error("violation flag dropped");
  erase_len_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(state_q == FBP_WIPE) |-> ##255 (state_q == FBP_WIPE) ##1 rsp_valid_o)
    else $error("erase length wrong");
  // One pair of checks per region
  for (genvar g = 0; g < REGIONS; g++) begin : g_prot_chk
    prot_sticky_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      ro_set_i[g] || ro_q[g] |=> ro_q[g])
      else $error("read-only bit not held");
    xo_sticky_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      xo_set_i[g] || xo_q[g] |=> xo_q[g])
      else $error("execute-only bit not held");
  end

  // Last cycle's addressed word and address, read only by checks
  logic [31:0]        seen_word_q;
  logic [WADDR_W-1:0] seen_addr_q;
  always_ff @(posedge mclk_i) begin
    seen_word_q <= mem_q[waddr];
    seen_addr_q <= waddr;
  end

  ro_erase_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_ERASE && ro_q[region] |=> state_q == FBP_IDLE && rsp_o.denied)
    else $error("erase of read-only region not refused");
  xo_prog_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_PROGRAM && xo_q[region] |=> rsp_valid_o && rsp_o.denied)
    else $error("program of execute-only region not refused");
  dread_xo_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_DREAD && xo_q[region] |=> rsp_o.denied && !rsp_o.ok)
    else $error("data read of execute-only region served");
  plain_read_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && (req_i.op == FBP_DREAD || req_i.op == FBP_DBG_READ) && !xo_q[region]
    |=> rsp_valid_o && rsp_o.ok)
    else $error("read of readable region refused");
  rdata_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && deny |=> !rsp_o.ok && rsp_o.rdata == 32'h0000_0000)
    else $error("refused request returned data");
  viol_clr_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    viol_q && viol_clr_i && !(take && deny) |=> !viol_q)
    else $error("violation flag not cleared");
  viol_quiet_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !viol_q && !(take && deny) |=> !viol_q)
    else $error("violation flag set without a refusal");
  // Unwritten words are unknown, so this needs the word erased first
  deny_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && deny |=> mem_q[seen_addr_q] == seen_word_q)
    else $error("refused request changed the array");
  fetch_data_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_IFETCH |=> rsp_o.rdata == seen_word_q)
    else $error("instruction fetch returned wrong word");
  // Erase sequencing
  wipe_start_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_ERASE && !deny
    |=> wipe_unit_q == seen_addr_q[WADDR_W-1:UOFF_W] && wipe_cnt_q == '0)
    else $error("erase started on wrong unit");
  erase_ok_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(state_q == FBP_WIPE) |-> rsp_o.ok && !rsp_o.denied)
    else $error("allowed erase reported refused");
  busy_ignore_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == FBP_WIPE && !(&wipe_cnt_q) |=> !rsp_valid_o && !req_ready_o)
    else $error("request answered during erase");
  unit_stay_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == FBP_WIPE && !(&wipe_cnt_q) |=> $stable(wipe_unit_q))
    else $error("erase unit changed mid-erase");
  wipe_val_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    state_q == FBP_WIPE |=> mem_q[$past({wipe_unit_q, wipe_cnt_q})] == ERASED_WORD)
    else $error("erased word not all ones");

  erase_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_ERASE && !deny);
  deny_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_DREAD && deny);
  fetch_xo_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_IFETCH && xo_q[region]);
  viol_clr_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    viol_q && viol_clr_i);
  ro_prog_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    take && req_i.op == FBP_PROGRAM && ro_q[region]);
endmodule : fbp_gate
`default_nettype wire

// File: shared/fbp_pkg.sv
// Constants and carrier types for the flash erase/protect gate.
// Assumes one 250 MHz clock and a byte-addressed 64 KB flash array of 32-bit words.
package fbp_pkg;
  localparam int unsigned FLASH_BYTES  = 65536;
  localparam int unsigned UNIT_BYTES   = 1024;
  localparam int unsigned REGION_BYTES = 2048;
  localparam int unsigned WORD_BYTES   = 4;
  localparam int unsigned WORDS        = FLASH_BYTES / WORD_BYTES;
  localparam int unsigned UNIT_WORDS   = UNIT_BYTES / WORD_BYTES;
  localparam int unsigned UNITS        = FLASH_BYTES / UNIT_BYTES;
  localparam int unsigned REGIONS      = FLASH_BYTES / REGION_BYTES;
  localparam int unsigned ADDR_W       = $clog2(FLASH_BYTES);
  localparam int unsigned WADDR_W      = $clog2(WORDS);
  localparam int unsigned UOFF_W       = $clog2(UNIT_WORDS);
  localparam int unsigned UNIT_W       = $clog2(UNITS);
  localparam int unsigned REG_W        = $clog2(REGIONS);
  localparam int unsigned REG_LSB      = $clog2(REGION_BYTES);
  localparam int unsigned UNIT_LSB     = $clog2(UNIT_BYTES);
  localparam int unsigned WORD_LSB     = $clog2(WORD_BYTES);
  localparam logic [31:0] ERASED_WORD  = 32'hFFFF_FFFF;
  localparam logic [REGIONS-1:0] PROT_RST = '0;

  typedef enum logic [2:0] {
    FBP_IFETCH,
    FBP_DREAD,
    FBP_DBG_READ,
    FBP_PROGRAM,
    FBP_ERASE
  } fbp_op_t;

  typedef struct packed {
    fbp_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } fbp_req_t;

  typedef struct packed {
    logic        ok;
    logic        denied;
    logic [31:0] rdata;
  } fbp_rsp_t;
endpackage : fbp_pkg
